// file: include/tap_pkg.sv
// Constants, types and helpers shared by the boundary-scan test port
`default_nettype none
package tap_pkg;
  localparam int IR_W = 3;
  localparam int BSR_LEN = 107;
  localparam int IDENT_W = 32;
  localparam int OE_CELL = 47;
  localparam int REV_W = 3;
  localparam int PART_W = 17;
  localparam int MAKER_W = 11;
  localparam int REV_LSB = 29;
  localparam int PART_LSB = 12;
  localparam int MAKER_LSB = 1;
  localparam int PRESENT_BIT = 0;

  localparam logic [IR_W-1:0] INS_EXT_TEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDENT = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_RESET_VAL = INS_IDENT;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic OE_CELL_RESET = 1'b1;
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;

  typedef enum logic [3:0] {
    ST_RESET = 4'hf,
    ST_IDLE = 4'hc,
    ST_SEL_DR = 4'h7,
    ST_CAP_DR = 4'h6,
    ST_SHIFT_DR = 4'h2,
    ST_EXIT1_DR = 4'h1,
    ST_PAUSE_DR = 4'h3,
    ST_EXIT2_DR = 4'h0,
    ST_UPD_DR = 4'h5,
    ST_SEL_IR = 4'h4,
    ST_CAP_IR = 4'he,
    ST_SHIFT_IR = 4'ha,
    ST_EXIT1_IR = 4'h9,
    ST_PAUSE_IR = 4'hb,
    ST_EXIT2_IR = 4'h8,
    ST_UPD_IR = 4'hd
  } tap_state_t;

  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0,
    DR_IDENT = 2'h1,
    DR_BSR = 2'h2
  } dr_sel_t;

  // Serial pins from the test controller
  typedef struct packed {
    logic tms;
    logic tdi;
  } tap_pins_t;

  // Unused codes fall back to the one-bit path so a chain stays intact
  function automatic dr_sel_t dr_select(input logic [IR_W-1:0] ir);
    dr_sel_t sel;
    sel = DR_BYPASS;
    if (ir == INS_IDENT) begin
      sel = DR_IDENT;
    end else if (ir == INS_EXT_TEST || ir == INS_SAMPLE_Z || ir == INS_SAMPLE_PRELOAD) begin
      sel = DR_BSR;
    end
    return sel;
  endfunction
endpackage
`default_nettype wire

// file: hdl/tap_fsm.sv
// Sixteen-state test port controller sequencer
`default_nettype none
module tap_fsm
  import tap_pkg::*;
(
  // Test clock domain
  input wire logic tck,
  input wire logic rst,
  input wire logic tms,
  // Controller state
  output tap_state_t state
);
  typedef struct packed {
    tap_state_t st;
  } fsm_state_t;

  fsm_state_t f_q;
  fsm_state_t f_d;

  always_comb begin
    f_d = f_q;
    unique case (f_q.st)
      ST_RESET: f_d.st = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: f_d.st = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: f_d.st = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: f_d.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: f_d.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: f_d.st = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: f_d.st = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: f_d.st = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: f_d.st = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: f_d.st = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: f_d.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: f_d.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: f_d.st = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: f_d.st = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: f_d.st = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: f_d.st = tms ? ST_SEL_DR : ST_IDLE;
    endcase
    if (rst) begin
      f_d.st = ST_RESET;
    end
  end

  always_ff @(posedge tck) begin
    f_q <= f_d;
  end

  assign state = f_q.st;
endmodule
`default_nettype wire

// file: hdl/sram_boundary_scan_tap.sv
// Boundary-scan test access port of the memory: registers, chain and pin control
`default_nettype none
// Behaviour
// - Code 000 puts the 107-cell chain in the serial path and captures the pin ring into it.
// - The identification code loads the fixed 32-bit identity word into the serial path.
// - Code 010 captures the ring, selects the chain and forces all memory outputs off.
// - Code 100 captures the ring and selects the chain without touching memory traffic.
// - Code 111 puts the one-bit bypass register in the serial path.
// - Identity bits are revision 31:29, part 28:12, maker 11:1 and a one in bit 0.
// - Under code 000 the updated cell 47 enables the outputs when one, disables when zero.
// - Cell 47's latch is set to one at reset and on every entry to test-logic-reset.
// - Under code 000 the chain's updated latches drive the ring's output pins.
module sram_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter logic [REV_W-1:0] REV_CODE = 3'h2, // Arbitrary value
  parameter logic [PART_W-1:0] PART_CODE = 17'h00a5a, // Arbitrary value
  parameter logic [MAKER_W-1:0] MAKER_CODE = 11'h155 // Arbitrary value
) (
  // System clock domain
  input wire logic sys_clk,
  input wire logic reset,
  // Test link
  input wire logic tck,
  input wire tap_pins_t pins,
  output logic tdo,
  output logic tdo_oe,
  // Pin ring
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic [BSR_LEN-1:0] ring_out,
  output logic ring_drive,
  output logic q_oe,
  // Status toward the memory core
  output logic extest_active,
  output logic outputs_forced_off
);
  localparam logic [IDENT_W-1:0] IDENT_WORD =
    {REV_CODE, PART_CODE, MAKER_CODE, 1'b1};

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [BSR_LEN-1:0] ring_meta;
    logic [BSR_LEN-1:0] ring_sync;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp_sh;
    logic [IDENT_W-1:0] ident_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic drive;
    logic q_oe;
  } tck_state_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } neg_state_t;

  typedef struct packed {
    logic rst_req;
    logic ext_meta;
    logic ext_sync;
    logic off_meta;
    logic off_sync;
  } sys_state_t;

  tck_state_t t_q;
  tck_state_t t_d;
  neg_state_t n_q;
  neg_state_t n_d;
  sys_state_t s_q;
  sys_state_t s_d;
  tap_state_t st;
  dr_sel_t sel;

  tap_fsm u_fsm (
    .tck(tck),
    .rst(t_q.rst_sync),
    .tms(pins.tms),
    .state(st)
  );

  assign sel = dr_select(t_q.ir);

  // Test clock domain
  always_comb begin
    t_d = t_q;
    t_d.rst_meta = s_q.rst_req;
    t_d.rst_sync = t_q.rst_meta;
    // Ring pins may move mid-capture; the doubled flops bound metastability only
    t_d.ring_meta = ring_in;
    t_d.ring_sync = t_q.ring_meta;
    if (t_q.rst_sync || st == ST_RESET) begin
      t_d.ir = IR_RESET_VAL;
      t_d.bsr_upd[OE_CELL] = OE_CELL_RESET;
    end else if (st == ST_CAP_IR) begin
      t_d.ir_sh = IR_CAPTURE_VAL;
    end else if (st == ST_SHIFT_IR) begin
      t_d.ir_sh = {pins.tdi, t_q.ir_sh[IR_W-1:1]};
    end else if (st == ST_UPD_IR) begin
      // Unused codes are taken but act as bypass
      t_d.ir = t_q.ir_sh;
    end else if (st == ST_CAP_DR) begin
      if (sel == DR_IDENT) begin
        t_d.ident_sh = IDENT_WORD;
      end else if (sel == DR_BSR) begin
        t_d.bsr_sh = t_q.ring_sync;
      end else begin
        t_d.byp_sh = BYPASS_CAPTURE_VAL;
      end
    end else if (st == ST_SHIFT_DR) begin
      if (sel == DR_IDENT) begin
        t_d.ident_sh = {pins.tdi, t_q.ident_sh[IDENT_W-1:1]};
      end else if (sel == DR_BSR) begin
        t_d.bsr_sh = {pins.tdi, t_q.bsr_sh[BSR_LEN-1:1]};
      end else begin
        t_d.byp_sh = pins.tdi;
      end
    end else if (st == ST_UPD_DR && sel == DR_BSR) begin
      t_d.bsr_upd = t_q.bsr_sh;
    end
    t_d.drive = (t_d.ir == INS_EXT_TEST);
    if (t_d.drive) begin
      t_d.q_oe = t_d.bsr_upd[OE_CELL];
    end else begin
      t_d.q_oe = (t_d.ir != INS_SAMPLE_Z);
    end
  end

  always_ff @(posedge tck) begin
    t_q <= t_d;
  end

  // Serial output moves on the falling edge to give the controller half a cycle
  always_comb begin
    n_d = '0;
    // Held low outside the shift states so the idle link shows no stale bit
    if (!t_q.rst_sync && (st == ST_SHIFT_IR || st == ST_SHIFT_DR)) begin
      n_d.tdo_oe = 1'b1;
      if (st == ST_SHIFT_IR) begin
        n_d.tdo = t_q.ir_sh[0];
      end else if (sel == DR_IDENT) begin
        n_d.tdo = t_q.ident_sh[0];
      end else if (sel == DR_BSR) begin
        n_d.tdo = t_q.bsr_sh[0];
      end else begin
        n_d.tdo = t_q.byp_sh;
      end
    end
  end

  always_ff @(negedge tck) begin
    n_q <= n_d;
  end

  // System clock domain
  always_comb begin
    s_d.rst_req = reset;
    s_d.ext_meta = t_q.drive;
    s_d.ext_sync = s_q.ext_meta;
    s_d.off_meta = ~t_q.q_oe;
    s_d.off_sync = s_q.off_meta;
    if (reset) begin
      s_d.ext_meta = 1'b0;
      s_d.ext_sync = 1'b0;
      s_d.off_meta = 1'b0;
      s_d.off_sync = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  assign tdo = n_q.tdo;
  assign tdo_oe = n_q.tdo_oe;
  assign ring_out = t_q.bsr_upd;
  assign ring_drive = t_q.drive;
  assign q_oe = t_q.q_oe;
  assign extest_active = s_q.ext_sync;
  assign outputs_forced_off = s_q.off_sync;
endmodule
`default_nettype wire

// file: dv/tap_checker.sv
// Port-level assertions for the boundary-scan test port
`default_nettype none
module tap_checker
  import tap_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tck,
  // Observed outputs
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BSR_LEN-1:0] ring_out,
  input wire logic ring_drive,
  input wire logic q_oe,
  input wire logic extest_active,
  input wire logic outputs_forced_off
);
  timeunit 1ns;
  timeprecision 1ps;
  a_extest_oe: assert property (@(posedge tck) disable iff (reset)
    ring_drive |-> q_oe == ring_out[OE_CELL]) else $error("cell 47 not obeyed");
  a_tdo_quiet: assert property (@(posedge tck) disable iff (reset)
    !tdo_oe |-> !tdo) else $error("tdo set outside shift");
  a_shift_hold: assert property (@(posedge tck) disable iff (reset)
    tdo_oe |-> $stable(ring_out) && $stable(q_oe) && $stable(ring_drive))
    else $error("pin control moved while shifting");
  a_reset_preset: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> ring_out[OE_CELL] && q_oe && !ring_drive)
    else $error("cell 47 not preset by reset");
  // Levels must stand four samples so the two-flop sync has settled
  a_sync_drive_on: assert property (@(posedge sys_clk) disable iff (reset)
    ring_drive [*4] |-> extest_active) else $error("extest status late");
  a_sync_drive_off: assert property (@(posedge sys_clk) disable iff (reset)
    !ring_drive [*4] |-> !extest_active) else $error("extest status stuck");
  a_sync_off_on: assert property (@(posedge sys_clk) disable iff (reset)
    !q_oe [*4] |-> outputs_forced_off) else $error("forced-off status late");
  a_sync_off_off: assert property (@(posedge sys_clk) disable iff (reset)
    q_oe [*4] |-> !outputs_forced_off) else $error("forced-off status stuck");
  c_extest_off: cover property (@(posedge tck) ring_drive && !q_oe);
  c_forced: cover property (@(posedge sys_clk) outputs_forced_off);
  c_shift: cover property (@(posedge tck) tdo_oe && tdo);
endmodule
bind sram_boundary_scan_tap tap_checker tap_checker_i (.sys_clk(sys_clk), .reset(reset),
  .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .ring_out(ring_out), .ring_drive(ring_drive),
  .q_oe(q_oe), .extest_active(extest_active), .outputs_forced_off(outputs_forced_off));
`default_nettype wire

// file: dv/tap_ctrl_model.sv
// Behavioural boundary-scan test controller on the test link
`default_nettype none
module tap_ctrl_model
  import tap_pkg::*;
(
  // Test link
  input wire logic tck,
  input wire logic tdo,
  output var tap_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = '{tms: 1'b1, tdi: 1'b1};
  task automatic step(input logic m, input logic d, output logic o);
    pins <= '{tms: m, tdi: d};
    @(posedge tck);
    o = tdo;
  endtask
  // Idle to shift, n bits LSB first, update, back to idle; IR codes 011, 101 and 110 return without scanning
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic o;
    dout = '0;
    @(posedge tck);
    if (ir && din[2:0] inside {3'h3, 3'h5, 3'h6}) return;
    if (ir) step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the boundary-scan test port
`default_nettype none
module tb
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity values
  localparam logic [2:0] REV = 3'h5;
  localparam logic [16:0] PART = 17'h1b3c6;
  localparam logic [10:0] MAKER = 11'h2e9;
  logic sys_clk = 1'b0;
  logic tck = 1'b0;
  logic reset = 1'b1;
  logic [BSR_LEN-1:0] ring_in = '0;
  logic [BSR_LEN-1:0] ring_out;
  tap_pins_t pins;
  logic tdo, tdo_oe, ring_drive, q_oe, extest_active, outputs_forced_off, o;
  int failures = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h49;
  logic [127:0] din, dout, cap;
  always #10 sys_clk = ~sys_clk;
  always #7.5 tck = ~tck;
  sram_boundary_scan_tap #(.REV_CODE(REV), .PART_CODE(PART), .MAKER_CODE(MAKER))
    sram_boundary_scan_tap_i (.sys_clk(sys_clk), .reset(reset), .tck(tck), .pins(pins),
    .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
    .ring_drive(ring_drive), .q_oe(q_oe), .extest_active(extest_active),
    .outputs_forced_off(outputs_forced_off));
  tap_ctrl_model tap_ctrl_model_i (.tck(tck), .tdo(tdo), .pins(pins));
  function automatic logic [127:0] rnd4();
    for (int i = 0; i < 4; i++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd4 = {rnd4[95:0], seed};
    end
  endfunction
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge tck);
    tap_ctrl_model_i.step(1'b0, 1'b0, o);
    @(negedge tck);
  endtask
  task automatic ir(input logic [IR_W-1:0] code);
    tap_ctrl_model_i.scan(1'b1, IR_W, {125'h0, code}, dout);
    @(negedge tck);
  endtask
  // Fresh ring levels, given time to pass the input synchroniser
  task automatic dr(input int n, input logic [127:0] d);
    @(posedge sys_clk);
    cap = rnd4();
    ring_in <= cap[106:0];
    repeat (4) @(posedge tck);
    tap_ctrl_model_i.scan(1'b0, n, d, dout);
    @(negedge tck);
  endtask
  initial begin
    do_reset();
    chk("reset_oe", {ring_drive, q_oe, ring_out[OE_CELL]}, 3'b011);
    dr(IDENT_W, rnd4());
    chk("ident", dout[31:0], {REV, PART, MAKER, 1'b1});
    ir(INS_BYPASS);
    chk("ir_capture", dout[2:0], IR_CAPTURE_VAL);
    chk("tdo_idle", {tdo_oe, tdo}, 2'b00);
    din = rnd4();
    dr(2, din);
    chk("bypass", dout[1:0], {din[0], BYPASS_CAPTURE_VAL});
    for (int k = 0; k < 2; k++) begin
      ir(INS_SAMPLE_PRELOAD);
      din = rnd4();
      din[OE_CELL] = k[0];
      dr(BSR_LEN, din);
      chk("preload_cap", dout[106:0], cap[106:0]);
      chk("preload_upd", {ring_drive, q_oe, ring_out}, {2'b01, din[106:0]});
      ir(INS_EXT_TEST);
      chk("extest_pins", {ring_drive, q_oe, ring_out}, {1'b1, din[47], din[106:0]});
      repeat (5) @(posedge sys_clk);
      chk("extest_sys", {extest_active, outputs_forced_off}, {1'b1, ~din[47]});
      din = rnd4();
      din[OE_CELL] = ~k[0];
      dr(BSR_LEN, din);
      chk("extest_cap", dout[106:0], cap[106:0]);
      chk("extest_upd", {q_oe, ring_out}, {din[OE_CELL], din[106:0]});
    end
    ir(INS_SAMPLE_Z);
    dr(BSR_LEN, rnd4());
    chk("samplez_cap", dout[106:0], cap[106:0]);
    repeat (5) @(posedge sys_clk);
    chk("samplez_oe", {q_oe, outputs_forced_off, extest_active}, 3'b010);
    do_reset();
    chk("rereset_oe", {ring_drive, q_oe, ring_out[OE_CELL]}, 3'b011);
    conclude();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
